// File: rtl/dsp_mem_map.sv
// Reset sequencing, on-chip memories and overlay memory map decode.
`timescale 1ns/1ps
`default_nettype none
module dsp_mem_map (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Straps and system status.
   input wire logic modeStrap,
   input wire logic busReq,
   input wire logic bootDone,
   // Register bus, Avalon-MM slave.
   input wire logic [dsp_map_pkg::BUS_AW-1:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [dsp_map_pkg::BUS_DW-1:0] avWritedata,
   output logic [dsp_map_pkg::BUS_DW-1:0] avReaddata,
   output logic avWaitrequest,
   // Core control.
   output logic ctxClear,
   output logic bootBusy,
   output logic coreRun,
   output logic pcLoad,
   output logic [13:0] pcStart,
   // Instruction fetch port.
   input wire logic [13:0] fetchAddr,
   output logic [23:0] fetchData,
   // Program memory data port.
   input wire dsp_map_pkg::memReq_s pmReq,
   output logic pmDone,
   output logic [23:0] pmRdata,
   // Data memory port.
   input wire dsp_map_pkg::memReq_s dmReq,
   output logic dmDone,
   output logic [15:0] dmRdata,
   // Memory-mapped control register window.
   input wire logic [15:0] mmrRdata,
   output logic mmrWr,
   output logic [4:0] mmrAddr,
   output logic [15:0] mmrWdata,
   // External overlay bus.
   output dsp_map_pkg::extBus_s extBus,
   input wire logic [23:0] extRdata,
   // Byte memory and I/O space addressing.
   input wire logic [7:0] bytePage,
   input wire logic [13:0] byteOffset,
   output logic [21:0] byteMemAddr,
   input wire logic ioReq,
   input wire logic [10:0] ioAddrIn,
   output logic ioSel,
   output logic [13:0] ioAddr
);
   import dsp_map_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   // Every flip-flop of the block except the RAM arrays.
   typedef struct packed {
      phase_e phase;
      logic strap;
      logic [1:0] pmOvl;
      logic [1:0] dmOvl;
      logic [2:0] waits;
      logic [7:0] mode;
      logic bootEn;
      logic waitReq;
      logic [31:0] rdata;
      logic ctxClr;
      logic bootBusy;
      logic coreRun;
      logic pcLoad;
      logic [23:0] ifData;
      logic pmDone;
      logic [23:0] pmRdata;
      logic dmDone;
      logic [15:0] dmRdata;
      logic mmrWr;
      logic [4:0] mmrAddr;
      logic [15:0] mmrWdata;
      logic extIsDm;
      logic [2:0] extCnt;
      extBus_s ext;
      logic [21:0] byteAddr;
      logic ioSel;
      logic [13:0] ioAddr;
   } state_s;

   // Reset image: context cleared, bus stalled, boot enabled, mode cleared.
   localparam state_s RESET_STATE = '{
      phase: ST_RST,
      waitReq: 1'b1,
      ctxClr: 1'b1,
      bootEn: CTRL_BOOT_RST,
      waits: WAIT_RST,
      mode: MODE_RST,
      default: '0
   };

   state_s s_r; // Registered state.
   state_s s_nxt; // Next state.

   // Program RAM, 16K x 24, and data RAM, 16K x 16.
   logic [23:0] pmRam [0:RAM_WORDS-1];
   logic [15:0] dmRam [0:RAM_WORDS-1];
   logic pmWrEn; // Internal program write this cycle.
   logic dmWrEn; // Internal data write this cycle.

   // Decode results of both spaces.
   logic pmExt;
   logic [13:0] pmExtAddr;
   logic dmExt;
   logic [13:0] dmExtAddr;

   ////////////////////////////////////////////////////////////////////////////
   // Decoders

   // Program overlay is the upper half; the strap moves the lower half outside.
   ovl_decode #(.OVL_HALF(1'b1)) u_pmDec (
      .addr(pmReq.addr),
      .ovlSel(s_r.pmOvl),
      .lowExt(s_r.strap),
      .isExt(pmExt),
      .extAddr(pmExtAddr)
   );

   // Data overlay is the lower half; the strap has no effect on data space.
   ovl_decode #(.OVL_HALF(1'b0)) u_dmDec (
      .addr(dmReq.addr),
      .ovlSel(s_r.dmOvl),
      .lowExt(1'b0),
      .isExt(dmExt),
      .extAddr(dmExtAddr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Register bus, reset phases and memory access sequencing.
   always_comb begin
      logic acc;
      logic pmGo;
      logic dmGo;
      logic dmMmr;
      logic memOk;
      logic [31:0] rmux;
      acc = avRead || avWrite;
      pmGo = (pmReq.rd || pmReq.wr) && !s_r.pmDone;
      dmGo = (dmReq.rd || dmReq.wr) && !s_r.dmDone;
      dmMmr = dmReq.addr >= MMR_BASE;
      memOk = (s_r.phase == ST_BOOT) || (s_r.phase == ST_RUN);
      rmux = '0;
      s_nxt = s_r;
      pmWrEn = 1'b0;
      dmWrEn = 1'b0;
      // Pulses last one cycle.
      s_nxt.pmDone = 1'b0;
      s_nxt.dmDone = 1'b0;
      s_nxt.mmrWr = 1'b0;
      s_nxt.pcLoad = 1'b0;

      // Read multiplexer; unmapped offsets read as zero.
      unique case (avAddress)
         OFF_PROG_OVL: rmux[1:0] = s_r.pmOvl;
         OFF_DATA_OVL: rmux[1:0] = s_r.dmOvl;
         OFF_WAITS: rmux[2:0] = s_r.waits;
         OFF_MODE: rmux[7:0] = s_r.mode;
         OFF_CTRL: rmux[CTRL_BOOT_BIT] = s_r.bootEn;
         OFF_STATUS: begin
            rmux[STAT_STRAP_BIT] = s_r.strap;
            rmux[STAT_BOOT_BIT] = s_r.bootBusy;
            rmux[STAT_EXT_BIT] = s_r.phase == ST_EXT;
         end
         default: rmux = '0;
      endcase

      // First edge of a request drops waitrequest and latches read data.
      if (acc && s_r.waitReq) begin
         s_nxt.waitReq = 1'b0;
         s_nxt.rdata = rmux;
      end else if (acc) begin
         // The edge that sees waitrequest low takes the write.
         s_nxt.waitReq = 1'b1;
         if (avWrite) begin
            unique case (avAddress)
               OFF_PROG_OVL: begin
                  // Only codes 0 to 2 are taken; the strap pins the select at zero.
                  if (s_r.strap) begin
                     s_nxt.pmOvl = OVL_INT;
                  end else if (avWritedata[1:0] != 2'h3) begin
                     s_nxt.pmOvl = avWritedata[1:0];
                  end
               end
               OFF_DATA_OVL: begin
                  if (avWritedata[1:0] != 2'h3) begin
                     s_nxt.dmOvl = avWritedata[1:0];
                  end
               end
               OFF_WAITS: s_nxt.waits = avWritedata[2:0];
               OFF_MODE: s_nxt.mode = avWritedata[7:0];
               OFF_CTRL: s_nxt.bootEn = avWritedata[CTRL_BOOT_BIT];
               default: s_nxt.waitReq = 1'b1;
            endcase
         end
      end else begin
         s_nxt.waitReq = 1'b1;
      end

      // Phase sequencing.
      unique case (s_r.phase)
         ST_RST: begin
            // Strap caught after release; boot only if configured and bus idle.
            s_nxt.strap = modeStrap;
            if (s_r.bootEn && !modeStrap && !busReq) begin
               s_nxt.phase = ST_BOOT;
               s_nxt.bootBusy = 1'b1;
            end else begin
               // No settling wait on any reset: straight to run.
               s_nxt.phase = ST_RUN;
               s_nxt.ctxClr = 1'b0;
               s_nxt.coreRun = 1'b1;
               s_nxt.pcLoad = 1'b1;
            end
         end
         ST_BOOT: begin
            // Core stays held with cleared context until the loader ends.
            if (bootDone) begin
               s_nxt.phase = ST_RUN;
               s_nxt.bootBusy = 1'b0;
               s_nxt.ctxClr = 1'b0;
               s_nxt.coreRun = 1'b1;
               s_nxt.pcLoad = 1'b1;
            end
         end
         ST_RUN: begin
            // Start one external access; data side first.
            if (dmGo && dmExt && !dmMmr) begin
               s_nxt.phase = ST_EXT;
               s_nxt.extIsDm = 1'b1;
               s_nxt.extCnt = s_r.waits;
               s_nxt.ext = '{pmSel: 1'b0, dmSel: 1'b1, rd: dmReq.rd, wr: dmReq.wr,
                             addr: dmExtAddr, wdata: {8'h00, dmReq.wdata[15:0]}};
            end else if (pmGo && pmExt) begin
               s_nxt.phase = ST_EXT;
               s_nxt.extIsDm = 1'b0;
               s_nxt.extCnt = 3'h0;
               s_nxt.ext = '{pmSel: 1'b1, dmSel: 1'b0, rd: pmReq.rd, wr: pmReq.wr,
                             addr: pmExtAddr, wdata: pmReq.wdata};
            end
         end
         ST_EXT: begin
            // Hold the strobe for the loaded count (the waits for data, zero for program), then finish and release the bus.
            if (s_r.extCnt == 3'h0) begin
               s_nxt.phase = ST_RUN;
               s_nxt.ext = '0;
               if (s_r.extIsDm) begin
                  s_nxt.dmDone = 1'b1;
                  s_nxt.dmRdata = extRdata[15:0];
               end else begin
                  s_nxt.pmDone = 1'b1;
                  s_nxt.pmRdata = extRdata;
               end
            end else begin
               s_nxt.extCnt = s_r.extCnt - 3'h1;
            end
         end
      endcase

      // Internal accesses finish in one cycle; fetch and data read share the cycle.
      if (memOk) begin
         s_nxt.ifData = pmRam[fetchAddr];
         if (pmGo && !pmExt) begin
            s_nxt.pmDone = 1'b1;
            s_nxt.pmRdata = pmRam[pmReq.addr];
            pmWrEn = pmReq.wr;
         end
         if (dmGo && dmMmr) begin
            // Top 32 words reach the control registers, never the RAM.
            s_nxt.dmDone = 1'b1;
            s_nxt.dmRdata = mmrRdata;
            s_nxt.mmrWr = dmReq.wr;
            s_nxt.mmrAddr = dmReq.addr[4:0];
            s_nxt.mmrWdata = dmReq.wdata[15:0];
         end else if (dmGo && !dmExt) begin
            s_nxt.dmDone = 1'b1;
            s_nxt.dmRdata = dmRam[dmReq.addr];
            dmWrEn = dmReq.wr;
         end
      end

      // Byte memory page joins the offset; I/O uses the low eleven bits.
      s_nxt.byteAddr = {bytePage, byteOffset};
      s_nxt.ioSel = ioReq;
      s_nxt.ioAddr = {3'h0, ioAddrIn};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // State register; reset clears context and mode.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= RESET_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // RAM write ports; the RAM arrays have no reset, unlike the state register.
   always_ff @(posedge clk_sys) begin
      if (pmWrEn) begin
         pmRam[pmReq.addr] <= pmReq.wdata;
      end
      if (dmWrEn) begin
         dmRam[dmReq.addr] <= dmReq.wdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Every output except pcStart, which is tied to BOOT_START, is a field of the state register.
   assign avReaddata = s_r.rdata;
   assign avWaitrequest = s_r.waitReq;
   assign ctxClear = s_r.ctxClr;
   assign bootBusy = s_r.bootBusy;
   assign coreRun = s_r.coreRun;
   assign pcLoad = s_r.pcLoad;
   assign pcStart = BOOT_START;
   assign fetchData = s_r.ifData;
   assign pmDone = s_r.pmDone;
   assign pmRdata = s_r.pmRdata;
   assign dmDone = s_r.dmDone;
   assign dmRdata = s_r.dmRdata;
   assign mmrWr = s_r.mmrWr;
   assign mmrAddr = s_r.mmrAddr;
   assign mmrWdata = s_r.mmrWdata;
   assign extBus = s_r.ext;
   assign byteMemAddr = s_r.byteAddr;
   assign ioSel = s_r.ioSel;
   assign ioAddr = s_r.ioAddr;
endmodule
`default_nettype wire

// File: inc/dsp_map_pkg.sv
// Shared constants, types and register layout for the memory map decoder.
package dsp_map_pkg;

   // Address and data widths of the two memory spaces and the register bus.
   localparam int ADDR_W = 14;
   localparam int PM_W = 24;
   localparam int DM_W = 16;
   localparam int BUS_AW = 3;
   localparam int BUS_DW = 32;
   localparam int RAM_WORDS = 16384;

   // Register word offsets on the register bus.
   localparam logic [2:0] OFF_PROG_OVL = 3'h0;
   localparam logic [2:0] OFF_DATA_OVL = 3'h1;
   localparam logic [2:0] OFF_WAITS = 3'h2;
   localparam logic [2:0] OFF_MODE = 3'h3;
   localparam logic [2:0] OFF_CTRL = 3'h4;
   localparam logic [2:0] OFF_STATUS = 3'h5;

   // Field positions and reset values.
   localparam int CTRL_BOOT_BIT = 0;
   localparam int STAT_STRAP_BIT = 0;
   localparam int STAT_BOOT_BIT = 1;
   localparam int STAT_EXT_BIT = 2;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [2:0] WAIT_RST = 3'h7;
   localparam logic CTRL_BOOT_RST = 1'b1;

   // Overlay select codes.
   localparam logic [1:0] OVL_INT = 2'h0;
   localparam logic [1:0] OVL_ONE = 2'h1;
   localparam logic [1:0] OVL_TWO = 2'h2;

   // Map boundaries.
   localparam logic [13:0] MMR_BASE = 14'h3fe0;
   localparam logic [13:0] BOOT_START = 14'h0000;

   // Life phases of the block, Gray coded along reset, boot, run, external.
   typedef enum logic [1:0] {
      ST_RST = 2'b00,
      ST_BOOT = 2'b01,
      ST_RUN = 2'b11,
      ST_EXT = 2'b10
   } phase_e;

   // One memory request from the core.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [13:0] addr;
      logic [23:0] wdata;
   } memReq_s;

   // External overlay bus as driven by the block.
   typedef struct packed {
      logic pmSel;
      logic dmSel;
      logic rd;
      logic wr;
      logic [13:0] addr;
      logic [23:0] wdata;
   } extBus_s;

endpackage

// File: rtl/ovl_decode.sv
// Overlay decode of one memory space: internal or external, and external address.
`timescale 1ns/1ps
`default_nettype none
module ovl_decode #(
   parameter logic OVL_HALF = 1'b1
) (
   // Access address and map settings.
   input wire logic [13:0] addr,
   input wire logic [1:0] ovlSel,
   input wire logic lowExt,
   // Decode result.
   output logic isExt,
   output logic [13:0] extAddr
);
   import dsp_map_pkg::*;

   // The overlay half goes out when a nonzero overlay is chosen; the strap moves the low half out.
   always_comb begin
      isExt = ((ovlSel != OVL_INT) && (addr[13] == OVL_HALF)) || (lowExt && !addr[13]);
      // Bit 13 names the overlay, the low 13 bits pass through; with the strap the whole address passes.
      extAddr = lowExt ? addr : {ovlSel == OVL_TWO, addr[12:0]};
   end
endmodule
`default_nettype wire

// File: testbench/mem_map_props.sv
// Port assertions for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module mem_map_props (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Watched ports.
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic avWaitrequest,
   input wire logic ctxClear,
   input wire logic bootBusy,
   input wire logic coreRun,
   input wire logic pcLoad,
   input wire logic [13:0] pcStart,
   input wire dsp_map_pkg::memReq_s pmReq,
   input wire logic pmDone,
   input wire dsp_map_pkg::memReq_s dmReq,
   input wire logic dmDone,
   input wire dsp_map_pkg::extBus_s extBus,
   input wire logic ioReq,
   input wire logic [10:0] ioAddrIn,
   input wire logic ioSel,
   input wire logic [13:0] ioAddr
);
   import dsp_map_pkg::*;
   // All checks run on the system clock and sleep through reset.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // First cycle of an external program access.
   sequence pmStart;
      $rose(extBus.pmSel);
   endsequence
   // First cycle of an external data access.
   sequence dmStart;
      $rose(extBus.dmSel);
   endsequence
   bus_answer_a: assert property ((avRead || avWrite) && avWaitrequest
      |=> !avWaitrequest ##1 avWaitrequest) else $error("Bus answer out of step.");
   boot_context_a: assert property (bootBusy |-> ctxClear) else $error("Context live in boot.");
   run_start_a: assert property ($rose(coreRun) |-> pcLoad && pcStart == 14'h0000 ##1 !pcLoad)
      else $error("Bad start of run.");
   one_strobe_a: assert property (!(extBus.pmSel && extBus.dmSel)) else $error("Two strobes.");
   strobe_needed_a: assert property ($rose(extBus.rd || extBus.wr)
      |-> extBus.pmSel || extBus.dmSel) else $error("Access without strobe.");
   pm_address_a: assert property (pmStart |-> $past(pmReq.rd || pmReq.wr)
      && extBus.addr[12:0] == $past(pmReq.addr[12:0])) else $error("Bad program address.");
   dm_address_a: assert property (dmStart |-> !$past(dmReq.addr[13])
      && extBus.addr[12:0] == $past(dmReq.addr[12:0])) else $error("Bad data address.");
   pm_done_a: assert property (pmStart |=> pmDone) else $error("Program access late.");
   dm_done_a: assert property (dmStart |-> ##[1:8] dmDone) else $error("Data access late.");
   io_addr_a: assert property (ioReq |=> ioSel && ioAddr == {3'b000, $past(ioAddrIn)})
      else $error("Bad I/O address.");
endmodule
bind dsp_mem_map mem_map_props u_props (.clk_sys, .arst_n, .avRead, .avWrite, .avWaitrequest,
   .ctxClear, .bootBusy, .coreRun, .pcLoad, .pcStart, .pmReq, .pmDone, .dmReq, .dmDone,
   .extBus, .ioReq, .ioAddrIn, .ioSel, .ioAddr);
`default_nettype wire

// File: testbench/ovl_mem_model.sv
// Model of the external overlay memories.
`timescale 1ns/1ps
`default_nettype none
module ovl_mem_model (
   // Clock.
   input wire logic clk_sys,
   // Overlay bus.
   input wire dsp_map_pkg::extBus_s extBus,
   output logic [23:0] extRdata
);
   import dsp_map_pkg::*;
   logic [23:0] mem [128]; // Small store keyed by space, bank bit and low bits.
   logic [23:0] idleMix_r = 24'h5a_5a5a; // Toggles so a stale bus never looks valid.
   logic [6:0] idx;
   assign idx = {extBus.pmSel, extBus.addr[13], extBus.addr[4:0]};
   // Writes land while a strobe and write are up.
   always_ff @(posedge clk_sys) begin
      idleMix_r <= ~idleMix_r;
      if ((extBus.pmSel || extBus.dmSel) && extBus.wr) begin
         mem[idx] <= extBus.wdata;
      end
   end
   assign extRdata = ((extBus.pmSel || extBus.dmSel) && extBus.rd) ? mem[idx] : idleMix_r;
endmodule
`default_nettype wire

// File: testbench/tb_dsp_mem_map.sv
// Self-checking bench of the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin samplesChecked++; if ((a) !== (e)) begin errTotal++; \
   $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_dsp_mem_map;
   import dsp_map_pkg::*;
   logic clk_sys, arst_n, modeStrap, busReq, bootDone, avRead, avWrite, avWaitrequest;
   logic ctxClear, bootBusy, coreRun, pcLoad, pmDone, dmDone, mmrWr, ioReq, ioSel, sawExt;
   logic [2:0] avAddress;
   logic [31:0] avWritedata, avReaddata;
   logic [13:0] pcStart, fetchAddr, byteOffset, ioAddr;
   logic [23:0] fetchData, pmRdata, extRdata;
   logic [15:0] dmRdata, mmrRdata, mmrWdata, mmrSeenD;
   logic [4:0] mmrAddr, mmrSeenA;
   logic [7:0] bytePage;
   logic [21:0] byteMemAddr;
   logic [10:0] ioAddrIn;
   memReq_s pmReq, dmReq;
   extBus_s extBus;
   int errTotal = 0, samplesChecked = 0, seed = 24035, cycles = 0;
   dsp_mem_map dut (.clk_sys, .arst_n, .modeStrap, .busReq, .bootDone, .avAddress, .avRead,
      .avWrite, .avWritedata, .avReaddata, .avWaitrequest, .ctxClear, .bootBusy, .coreRun,
      .pcLoad, .pcStart, .fetchAddr, .fetchData, .pmReq, .pmDone, .pmRdata, .dmReq, .dmDone,
      .dmRdata, .mmrRdata, .mmrWr, .mmrAddr, .mmrWdata, .extBus, .extRdata, .bytePage,
      .byteOffset, .byteMemAddr, .ioReq, .ioAddrIn, .ioSel, .ioAddr);
   ovl_mem_model far (.clk_sys, .extBus, .extRdata);
   // Clock at 250 MHz.
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Guard against a hang, and note strobes and register window writes.
   always @(posedge clk_sys) begin
      cycles++;
      if (extBus.pmSel || extBus.dmSel) sawExt = 1;
      if (mmrWr === 1'b1) begin
         mmrSeenA = mmrAddr;
         mmrSeenD = mmrWdata;
      end
      if (cycles == 20000) begin
         errTotal++;
         stopTest();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Data space keeps only the low 16 bits of a word.
   function automatic logic [23:0] dmKeep(input logic [23:0] v);
      return {8'h00, v[15:0]};
   endfunction
   // Prints the counts and the verdict, then ends the run.
   task automatic stopTest();
      $display("checks %0d errors %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One Avalon access, held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_sys);
      avAddress <= a;
      avWritedata <= d;
      avWrite <= w;
      avRead <= !w;
      do @(posedge clk_sys); while (avWaitrequest !== 1'b0);
      q = avReaddata;
      avRead <= 0;
      avWrite <= 0;
   endtask
   // Register read compared with an expected value.
   task automatic rg(input logic [2:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(0, a, 0, q);
      `CHK("reg", e, q)
   endtask
   // One memory request held until its done pulse; n counts the edges.
   task automatic mem(input logic d, input logic w, input logic [13:0] a, input logic [23:0] wd,
      output logic [23:0] q, output int n);
      memReq_s r;
      r = '{rd: !w, wr: w, addr: a, wdata: wd};
      @(posedge clk_sys);
      sawExt = 0;
      if (d) dmReq <= r;
      else pmReq <= r;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while ((d ? dmDone : pmDone) !== 1'b1);
      q = d ? {8'h00, dmRdata} : pmRdata;
      dmReq <= '0;
      pmReq <= '0;
   endtask
   // Read that checks data and whether the overlay strobe was used.
   task automatic rdc(input logic d, input logic [13:0] a, input logic [23:0] e, input logic x);
      logic [23:0] q;
      int n;
      mem(d, 0, a, 0, q, n);
      `CHK("rdExt", x, sawExt)
      `CHK("rdData", e, q)
      // Internal reads are taken on the first edge and seen done on the second.
      if (!x) `CHK("rdCycles", 2, n)
   endtask
   // Write then read back; data space keeps 16 bits.
   task automatic rw(input logic d, input logic [13:0] a, input logic [23:0] v, input logic x);
      logic [23:0] q;
      int n;
      mem(d, 1, a, v, q, n);
      `CHK("wrExt", x, sawExt)
      rdc(d, a, d ? dmKeep(v) : v, x);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [23:0] v, q;
      logic [23:0] pv [3];
      logic [13:0] a;
      logic [31:0] d;
      int n, w;
      {arst_n, modeStrap, busReq, bootDone, avRead, avWrite, ioReq} = '0;
      {avAddress, avWritedata, fetchAddr, mmrRdata, bytePage, byteOffset, ioAddrIn} = '0;
      pmReq = '0;
      dmReq = '0;
      // Power-up reset; the block has no clock multiplier, so this hold stands for the lock time.
      repeat (12) @(posedge clk_sys);
      arst_n <= 1;
      repeat (2) @(posedge clk_sys);
      `CHK("boot", 1'b1, bootBusy)
      `CHK("ctx", 1'b1, ctxClear)
      rg(OFF_WAITS, 7);
      rg(OFF_MODE, 0);
      rg(OFF_CTRL, 1);
      rg(OFF_STATUS, 32'h0000_0002);
      bus(1, 3'h7, 32'hffff_ffff, d);
      rg(3'h7, 0);
      v = 24'($random(seed));
      rw(0, 14'h0005, v, 0);
      fetchAddr <= 14'h0005;
      repeat (2) @(posedge clk_sys);
      `CHK("fetch", v, fetchData)
      bootDone <= 1;
      do @(posedge clk_sys); while (coreRun !== 1'b1);
      bootDone <= 0;
      `CHK("pc", 14'h0000, pcStart)
      `CHK("ctxRun", 1'b0, ctxClear)
      a = 14'($random(seed)) & 14'h1fff;
      for (int o = 1; o <= 2; o++) begin
         pv[o] = 24'($random(seed));
         bus(1, OFF_PROG_OVL, o, d);
         rw(0, a | 14'h2000, pv[o], 1);
         bus(1, OFF_DATA_OVL, o, d);
         rw(1, a, pv[o] ^ 24'h00_ffff, 1);
      end
      bus(1, OFF_PROG_OVL, 1, d);
      rdc(0, a | 14'h2000, pv[1], 1);
      bus(1, OFF_DATA_OVL, 1, d);
      rdc(1, a, dmKeep(pv[1] ^ 24'h00_ffff), 1);
      bus(1, OFF_PROG_OVL, 3, d);
      rg(OFF_PROG_OVL, 1);
      bus(1, OFF_PROG_OVL, 0, d);
      rw(0, a | 14'h2000, v, 0);
      bus(1, OFF_DATA_OVL, 0, d);
      rw(1, a, v, 0);
      rw(1, 14'h3fdf, v, 0);
      mmrRdata <= v[15:0];
      rdc(1, 14'h3fe9, {8'h00, v[15:0]}, 0);
      rw(1, 14'h3fe3, v, 0);
      `CHK("mmrAddr", 5'h03, mmrSeenA)
      `CHK("mmrData", v[15:0], mmrSeenD)
      bus(1, OFF_DATA_OVL, 2, d);
      for (int i = 0; i < 3; i++) begin
         w = (i == 0) ? 0 : (i == 1) ? 7 : ($random(seed) & 7);
         bus(1, OFF_WAITS, w, d);
         mem(1, 0, a, 0, q, n);
         // Taken on edge one, strobe for the waits, done set, then seen one edge later.
         `CHK("waits", w + 3, n)
      end
      for (int i = 0; i < 4; i++) begin
         bytePage <= 8'($random(seed));
         byteOffset <= 14'($random(seed));
         ioAddrIn <= 11'($random(seed));
         ioReq <= 1;
         repeat (2) @(posedge clk_sys);
         `CHK("byte", {bytePage, byteOffset}, byteMemAddr)
         `CHK("io", {3'b000, ioAddrIn}, ioAddr)
         `CHK("ioSel", 1'b1, ioSel)
      end
      // Drop the I/O request so no check straddles the resets below.
      ioReq <= 0;
      bus(1, OFF_MODE, 32'h0000_005a, d);
      rg(OFF_MODE, 32'h0000_005a);
      modeStrap <= 1;
      arst_n <= 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1;
      repeat (2) @(posedge clk_sys);
      `CHK("warmRun", 1'b1, coreRun)
      `CHK("noBoot", 1'b0, bootBusy)
      rg(OFF_MODE, 0);
      rg(OFF_STATUS, 32'h0000_0001);
      bus(1, OFF_PROG_OVL, 1, d);
      rg(OFF_PROG_OVL, 0);
      rw(0, a, v, 1);
      rw(0, a | 14'h2000, ~v, 0);
      // A pending bus request at release skips the boot load.
      modeStrap <= 0;
      busReq <= 1;
      arst_n <= 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1;
      repeat (2) @(posedge clk_sys);
      `CHK("reqNoBoot", 1'b0, bootBusy)
      `CHK("reqRun", 1'b1, coreRun)
      stopTest();
   end
endmodule
`default_nettype wire
